// ==== core/arar_defines.svh ====
// Functional notes
// RULE1 - range register bits 31 to 7 are reserved and always read as zero.
// RULE2 - range register bits 5 and 4 cannot be written and always read as 00b.
// RULE3 - range register bit 6 is read/write, resets to 0, and 1 turns the internal reference off.
// RULE4 - range codes 0000b to 0100b pick the bipolar spans of 3, 2.5, 1.5, 1.25 and 0.625 times ref.
// RULE5 - codes 1000b to 1011b pick unipolar spans of 3, 2.5, 1.5, 1.25 times ref; reset code 0000b.
// RULE6 - the range register is byte addressed, bits 15-8, 23-16, 31-24 at bytes 15h, 16h, 17h.
// RULE7 - the alarm register is read only and spans bytes 20h to 23h, low byte at 20h.
// RULE8 - every alarm flag resets to 0 and reads 1 while its alarm condition exists.
// RULE9 - alarm bit 15 is the live low-supply flag and bit 14 the live high-supply flag.
// RULE10 - alarm bit 11 is the live high-input flag and bit 10 the live low-input flag.
// RULE11 - alarm bit 7 is the latched low-supply flag and bit 6 the latched high-supply flag.
// RULE12 - alarm bit 5 is the latched high-input flag and bit 4 the latched low-input flag.
// RULE13 - alarm bit 0 is the OR of the four latched flags.
// RULE14 - alarm bits 31-16, 13-12, 9-8 and 3-1 are reserved and read as zero.
// RULE15 - the input alarm compares the result with 16-bit thresholds extended by two zero bits.
// RULE16 - live flags follow each conversion; latched flags hold until software reads the alarm word.
// RULE17 - writes to reserved bits or to the read-only alarm word change nothing.
`ifndef ARAR_DEFINES_SVH
`define ARAR_DEFINES_SVH

// ----------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------
`define ARAR_OFS_RANGE      8'h14
`define ARAR_OFS_ALARM      8'h20
`define ARAR_OFS_HI_THR     8'h24
`define ARAR_OFS_LO_THR     8'h28
`define ARAR_OFS_IRQ_STAT   8'h40
`define ARAR_OFS_IRQ_MASK   8'h44

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ARAR_RANGE_REF_BIT  6
`define ARAR_AL_LIVE_SUP_LO 15
`define ARAR_AL_LIVE_SUP_HI 14
`define ARAR_AL_LIVE_IN_HI  11
`define ARAR_AL_LIVE_IN_LO  10
`define ARAR_AL_TRIP_SUP_LO 7
`define ARAR_AL_TRIP_SUP_HI 6
`define ARAR_AL_TRIP_IN_HI  5
`define ARAR_AL_TRIP_IN_LO  4
`define ARAR_AL_ANY         0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ARAR_RST_RANGE      4'h0
`define ARAR_RST_REF_OFF    1'b0
`define ARAR_RST_HI_THR     16'hFFFF
`define ARAR_RST_LO_THR     16'h0000
`define ARAR_RST_WORD       32'h0000_0000

`endif

// ==== core/arar_pkg.sv ====
package arar_pkg;

  // bus answer sequencer, one-hot
  typedef enum logic [1:0] {
    ARAR_ST_IDLE = 2'b01,
    ARAR_ST_ACK  = 2'b10
  } arar_bus_st_t;

  // alarm sources, index into the internal 4-bit vectors
  typedef enum int unsigned {
    ARAR_SRC_IN_LO  = 0,
    ARAR_SRC_IN_HI  = 1,
    ARAR_SRC_SUP_HI = 2,
    ARAR_SRC_SUP_LO = 3
  } arar_src_t;

endpackage

// ==== core/arar_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "arar_defines.svh"

module arar_regs
  import arar_pkg::*;
#(
  parameter int RES_W = 18
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // avalon-mm slave
  input  wire logic [7:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  input  wire logic [3:0]       byteenable,
  output var  logic [31:0]      readdata,
  output var  logic             waitrequest,
  // conversion results, same clock
  input  wire logic [RES_W-1:0] conv_result,
  input  wire logic             conv_valid,
  // supply comparators, asynchronous pins
  input  wire logic             supply_low_pin,
  input  wire logic             supply_high_pin,
  // configuration to the analog side
  output var  logic             internal_ref_off,
  output var  logic [3:0]       range_code,
  output var  logic             range_unipolar,
  // alarm summary and interrupt
  output var  logic             any_latched_alarm,
  output var  logic             alarm_irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // only the nine documented spans are accepted
  function automatic logic range_code_ok(input logic [3:0] c);
    range_code_ok = (c <= 4'h4) || (c >= 4'h8 && c <= 4'hB); // [RULE4] [RULE5]
  endfunction

  // threshold widened with two low zeros to the result width
  function automatic logic [RES_W-1:0] thr_ext(input logic [15:0] t);
    thr_ext = {t, 2'b00}; // [RULE15]
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  arar_bus_st_t st_r,        st_nxt;
  logic         wait_r,      wait_nxt;
  logic [31:0]  rdata_r,     rdata_nxt;
  logic         ref_off_r,   ref_off_nxt;
  logic [3:0]   range_r,     range_nxt;
  logic         unip_r,      unip_nxt;
  logic [15:0]  hi_thr_r,    hi_thr_nxt;
  logic [15:0]  lo_thr_r,    lo_thr_nxt;
  logic [3:0]   live_r,      live_nxt;
  logic [3:0]   trip_r,      trip_nxt;
  logic         any_r,       any_nxt;
  logic [3:0]   istat_r,     istat_nxt;
  logic [3:0]   imask_r,     imask_nxt;
  logic         irq_r,       irq_nxt;
  logic [1:0]   sup_lo_sync_r;
  logic [1:0]   sup_hi_sync_r;
  logic         commit;
  logic         wr_commit;
  logic         rd_commit;
  logic [3:0]   cond;
  logic [31:0]  alarm_word;
  logic [31:0]  range_word;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_lo_sync_r <= 2'b00;
      sup_hi_sync_r <= 2'b00;
    end else begin
      sup_lo_sync_r <= {sup_lo_sync_r[0], supply_low_pin};
      sup_hi_sync_r <= {sup_hi_sync_r[0], supply_high_pin};
    end
  end

  // ----------------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------------

  // request is taken at the edge where waitrequest is seen low
  assign commit    = (st_r == ARAR_ST_ACK) && (read || write);
  assign wr_commit = commit && write;
  assign rd_commit = commit && read;

  // one wait cycle gives a registered read path; costs a cycle per access
  always_comb begin
    st_nxt   = st_r;
    wait_nxt = 1'b1;
    case (st_r)
      ARAR_ST_IDLE: begin
        if (read || write) begin
          st_nxt   = ARAR_ST_ACK;
          wait_nxt = 1'b0;
        end
      end
      ARAR_ST_ACK: begin
        st_nxt   = ARAR_ST_IDLE;
        wait_nxt = 1'b1;
      end
      default: begin
        st_nxt   = ARAR_ST_IDLE;
        wait_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r   <= ARAR_ST_IDLE;
      wait_r <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      wait_r <= wait_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------------

  // range word: only bits 6 and 3-0 carry state
  always_comb begin
    range_word = `ARAR_RST_WORD;                       // [RULE1] [RULE2]
    range_word[`ARAR_RANGE_REF_BIT] = ref_off_r;      // [RULE3]
    range_word[3:0] = range_r;                         // [RULE4] [RULE5]
  end

  // alarm word, reserved positions left at zero
  always_comb begin
    alarm_word = `ARAR_RST_WORD;                                     // [RULE14]
    alarm_word[`ARAR_AL_LIVE_SUP_LO] = live_r[ARAR_SRC_SUP_LO];     // [RULE9]
    alarm_word[`ARAR_AL_LIVE_SUP_HI] = live_r[ARAR_SRC_SUP_HI];     // [RULE9]
    alarm_word[`ARAR_AL_LIVE_IN_HI]  = live_r[ARAR_SRC_IN_HI];      // [RULE10]
    alarm_word[`ARAR_AL_LIVE_IN_LO]  = live_r[ARAR_SRC_IN_LO];      // [RULE10]
    alarm_word[`ARAR_AL_TRIP_SUP_LO] = trip_r[ARAR_SRC_SUP_LO];     // [RULE11]
    alarm_word[`ARAR_AL_TRIP_SUP_HI] = trip_r[ARAR_SRC_SUP_HI];     // [RULE11]
    alarm_word[`ARAR_AL_TRIP_IN_HI]  = trip_r[ARAR_SRC_IN_HI];      // [RULE12]
    alarm_word[`ARAR_AL_TRIP_IN_LO]  = trip_r[ARAR_SRC_IN_LO];      // [RULE12]
    alarm_word[`ARAR_AL_ANY]         = |trip_r;                      // [RULE13]
  end

  // read data is registered when waitrequest drops and holds to commit
  always_comb begin
    rdata_nxt = rdata_r;
    if (st_r == ARAR_ST_IDLE && read) begin
      case (address)
        `ARAR_OFS_RANGE:    rdata_nxt = range_word;               // [RULE6]
        `ARAR_OFS_ALARM:    rdata_nxt = alarm_word;               // [RULE7]
        `ARAR_OFS_HI_THR:   rdata_nxt = {16'h0000, hi_thr_r};
        `ARAR_OFS_LO_THR:   rdata_nxt = {16'h0000, lo_thr_r};
        `ARAR_OFS_IRQ_STAT: rdata_nxt = {28'h000_0000, istat_r};
        `ARAR_OFS_IRQ_MASK: rdata_nxt = {28'h000_0000, imask_r};
        default:            rdata_nxt = `ARAR_RST_WORD;          // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= `ARAR_RST_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------

  // only byte lane 0 of the range word holds writable bits
  always_comb begin
    ref_off_nxt = ref_off_r;
    range_nxt   = range_r;
    unip_nxt    = unip_r;
    hi_thr_nxt  = hi_thr_r;
    lo_thr_nxt  = lo_thr_r;
    imask_nxt   = imask_r;
    if (wr_commit) begin
      case (address)
        `ARAR_OFS_RANGE: begin
          if (byteenable[0]) begin
            ref_off_nxt = writedata[`ARAR_RANGE_REF_BIT];    // [RULE3]
            // unlisted codes would leave the front end undefined
            if (range_code_ok(writedata[3:0])) begin
              range_nxt = writedata[3:0];                    // [RULE4] [RULE5]
              unip_nxt  = writedata[3];
            end
          end
        end
        `ARAR_OFS_HI_THR: begin
          if (byteenable[0]) begin
            hi_thr_nxt[7:0] = writedata[7:0];
          end
          if (byteenable[1]) begin
            hi_thr_nxt[15:8] = writedata[15:8];
          end
        end
        `ARAR_OFS_LO_THR: begin
          if (byteenable[0]) begin
            lo_thr_nxt[7:0] = writedata[7:0];
          end
          if (byteenable[1]) begin
            lo_thr_nxt[15:8] = writedata[15:8];
          end
        end
        `ARAR_OFS_IRQ_MASK: begin
          if (byteenable[0]) begin
            imask_nxt = writedata[3:0];
          end
        end
        default: begin
          ref_off_nxt = ref_off_r;                           // [RULE17]
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_off_r <= `ARAR_RST_REF_OFF;                        // [RULE3]
      range_r   <= `ARAR_RST_RANGE;                          // [RULE5]
      unip_r    <= 1'b0;
      hi_thr_r  <= `ARAR_RST_HI_THR;
      lo_thr_r  <= `ARAR_RST_LO_THR;
      imask_r   <= 4'h0;
    end else begin
      ref_off_r <= ref_off_nxt;
      range_r   <= range_nxt;
      unip_r    <= unip_nxt;
      hi_thr_r  <= hi_thr_nxt;
      lo_thr_r  <= lo_thr_nxt;
      imask_r   <= imask_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // alarm flags
  // ----------------------------------------------------------------------

  // present condition: input flags judged against the widened thresholds, supply flags from the synchronisers
  always_comb begin
    cond = 4'h0;
    cond[ARAR_SRC_IN_HI]  = conv_result > thr_ext(hi_thr_r);  // [RULE15]
    cond[ARAR_SRC_IN_LO]  = conv_result < thr_ext(lo_thr_r);  // [RULE15]
    cond[ARAR_SRC_SUP_HI] = sup_hi_sync_r[1];
    cond[ARAR_SRC_SUP_LO] = sup_lo_sync_r[1];
  end

  // a trip that lands on the clearing read survives it
  always_comb begin
    live_nxt = live_r;
    trip_nxt = trip_r;
    if (rd_commit && address == `ARAR_OFS_ALARM) begin
      trip_nxt = 4'h0;                                       // [RULE16]
    end
    if (conv_valid) begin
      live_nxt = cond;                                       // [RULE16] [RULE8]
      trip_nxt = trip_nxt | cond;                            // [RULE16] [RULE8]
    end
    any_nxt = |trip_nxt;                                     // [RULE13]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_r <= 4'h0;                                        // [RULE8]
      trip_r <= 4'h0;                                        // [RULE8]
      any_r  <= 1'b0;
    end else begin
      live_r <= live_nxt;
      trip_r <= trip_nxt;
      any_r  <= any_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------

  // event is a flag newly latching; write-one clears, set wins
  always_comb begin
    istat_nxt = istat_r;
    if (wr_commit && address == `ARAR_OFS_IRQ_STAT && byteenable[0]) begin
      istat_nxt = istat_r & ~writedata[3:0];
    end
    if (conv_valid) begin
      istat_nxt = istat_nxt | (cond & ~trip_r);
    end
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      istat_r <= 4'h0;
      irq_r   <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign readdata          = rdata_r;
  assign waitrequest       = wait_r;
  assign internal_ref_off  = ref_off_r;
  assign range_code        = range_r;
  assign range_unipolar    = unip_r;
  assign any_latched_alarm = any_r;
  assign alarm_irq         = irq_r;

endmodule

`default_nettype wire

// ==== testbench/arar_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

module arar_regs_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // configuration and alarm outputs
  input wire logic        internal_ref_off,
  input wire logic [3:0]  range_code,
  input wire logic        range_unipolar,
  input wire logic        any_latched_alarm,
  input wire logic        alarm_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // bus answer timing
  // ----------------------------------------------------------------------
  a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_req_answered: assert property ((read || write) |-> ##[0:2] !waitrequest)
    else $error("request not answered within two cycles");

  // ----------------------------------------------------------------------
  // range word
  // ----------------------------------------------------------------------
  a_unipolar_bit: assert property (range_unipolar == range_code[3])
    else $error("unipolar output disagrees with code");
  a_code_legal: assert property (!(range_code inside {4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF}))
    else $error("range code holds an unlisted value");
  a_range_rsvd: assert property (read && address == 8'h14 && !waitrequest |->
    readdata[31:7] == 25'h0 && readdata[5:4] == 2'b00 && readdata[3:0] == range_code
    && readdata[6] == internal_ref_off)
    else $error("range word readback wrong");
  a_range_write: assert property (write && address == 8'h14 && !waitrequest && byteenable[0]
    && !(writedata[3:0] inside {4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF}) |=>
    range_code == $past(writedata[3:0]) && internal_ref_off == $past(writedata[6]))
    else $error("range write not applied");
  a_alarm_ro: assert property (write && address == 8'h20 |=>
    $stable(range_code) && $stable(internal_ref_off))
    else $error("alarm write disturbed configuration");

  // ----------------------------------------------------------------------
  // alarm word
  // ----------------------------------------------------------------------
  a_alarm_rsvd: assert property (read && address == 8'h20 && !waitrequest |->
    readdata[31:16] == 16'h0 && readdata[13:12] == 2'b00 && readdata[9:8] == 2'b00
    && readdata[3:1] == 3'b000)
    else $error("alarm reserved bits not zero");
  a_summary_or: assert property (read && address == 8'h20 && !waitrequest |->
    readdata[0] == (|readdata[7:4]))
    else $error("summary bit not OR of latched flags");
  // any_latched_alarm may only drop at a committed alarm read
  a_trip_hold: assert property (any_latched_alarm && !(read && address == 8'h20 && !waitrequest)
    |=> any_latched_alarm)
    else $error("latched alarm dropped without a read");

  // ----------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------
  a_irq_masked: assert property (write && address == 8'h44 && !waitrequest && byteenable[0]
    && writedata[3:0] == 4'h0 |=> !alarm_irq)
    else $error("interrupt raised while fully masked");
endmodule

`default_nettype wire

bind arar_regs arar_regs_checker i_chk (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .internal_ref_off(internal_ref_off),
  .range_code(range_code), .range_unipolar(range_unipolar),
  .any_latched_alarm(any_latched_alarm), .alarm_irq(alarm_irq)
);

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "arar_defines.svh"

module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [17:0] conv_result = 18'h0_0000;
  logic        conv_valid = 1'b0;
  logic        supply_low_pin = 1'b0;
  logic        supply_high_pin = 1'b0;
  logic        internal_ref_off;
  logic [3:0]  range_code;
  logic        range_unipolar;
  logic        any_latched_alarm;
  logic        alarm_irq;
  int          mismatches = 0;
  int          num_checks = 0;
  logic [31:0] rv;
  logic [3:0]  codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB};

  always #10 clk = ~clk;

  arar_regs i_dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .conv_result(conv_result), .conv_valid(conv_valid),
    .supply_low_pin(supply_low_pin), .supply_high_pin(supply_high_pin),
    .internal_ref_off(internal_ref_off), .range_code(range_code),
    .range_unipolar(range_unipolar), .any_latched_alarm(any_latched_alarm),
    .alarm_irq(alarm_irq)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus access raised just after a rising edge; waitrequest and readdata
  // are taken as they stand at the rising edge where waitrequest is low
  task automatic access(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0000_0000;
    address <= a;
    writedata <= d;
    write <= is_wr;
    read <= ~is_wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end else begin
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // one idle edge, so a following call never reraises in this step
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    access(1'b0, a, 32'h0000_0000, q);
  endtask

  // conversion pulse; flags land at the edge where conv_valid is high
  task automatic conv(input logic [17:0] v);
    conv_result <= v;
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset state
    chk({31'h0, internal_ref_off}, 32'h0000_0000);
    rd(`ARAR_OFS_RANGE, rv); chk(rv, 32'h0000_0000);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0000);
    rd(8'h15, rv); chk(rv, 32'h0000_0000);
    $display("reset test done");
    // every listed code, reserved bits written as ones
    for (int i = 0; i < 9; i++) begin
      wr(`ARAR_OFS_RANGE, 32'hFFFF_FFB0 | {25'h0, i[0], 6'h00} | {28'h0, codes[i]});
      rd(`ARAR_OFS_RANGE, rv);
      chk(rv, {25'h0, i[0], 2'b00, codes[i]});
      chk({27'h0, range_unipolar, range_code}, {27'h0, codes[i][3], codes[i]});
      chk({31'h0, internal_ref_off}, {31'h0, i[0]});
    end
    // unlisted code keeps the old code, reference bit still written
    wr(`ARAR_OFS_RANGE, 32'h0000_0005);
    rd(`ARAR_OFS_RANGE, rv); chk(rv, 32'h0000_000B);
    // upper lanes only reach bytes 15h-17h, which hold nothing
    byteenable <= 4'hE;
    wr(`ARAR_OFS_RANGE, 32'h0000_0041);
    byteenable <= 4'hF;
    rd(`ARAR_OFS_RANGE, rv); chk(rv, 32'h0000_000B);
    // alarm word and unmapped space ignore writes
    wr(`ARAR_OFS_ALARM, 32'hFFFF_FFFF);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0000);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, rv); chk(rv, 32'h0000_0000);
    rd(`ARAR_OFS_RANGE, rv); chk(rv, 32'h0000_000B);
    $display("range test done");
    // thresholds 0x100 and 0x080, compared as 0x400 and 0x200
    wr(`ARAR_OFS_HI_THR, 32'h0000_0100);
    wr(`ARAR_OFS_LO_THR, 32'h0000_0080);
    wr(`ARAR_OFS_IRQ_STAT, 32'h0000_000F);
    wr(`ARAR_OFS_IRQ_MASK, 32'h0000_0002);
    conv(18'h0_0400);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0000);
    chk({31'h0, alarm_irq}, 32'h0000_0000);
    conv(18'h0_0401);
    chk({30'h0, alarm_irq, any_latched_alarm}, 32'h0000_0003);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0821);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0800);
    wr(`ARAR_OFS_IRQ_MASK, 32'h0000_0000);
    chk({31'h0, alarm_irq}, 32'h0000_0000);
    rd(`ARAR_OFS_IRQ_STAT, rv); chk(rv, 32'h0000_0002);
    wr(`ARAR_OFS_IRQ_STAT, 32'h0000_0002);
    rd(`ARAR_OFS_IRQ_STAT, rv); chk(rv, 32'h0000_0000);
    conv(18'h0_01FF);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0411);
    conv(18'h0_0200);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0000);
    $display("input alarm test done");
    // supply comparators pass a two-stage synchroniser
    supply_low_pin <= 1'b1;
    repeat (4) @(posedge clk);
    conv(18'h0_0300);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_8081);
    supply_low_pin <= 1'b0;
    supply_high_pin <= 1'b1;
    repeat (4) @(posedge clk);
    conv(18'h0_0300);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_4041);
    supply_high_pin <= 1'b0;
    repeat (4) @(posedge clk);
    conv(18'h0_0300);
    rd(`ARAR_OFS_ALARM, rv); chk(rv, 32'h0000_0000);
    chk({31'h0, any_latched_alarm}, 32'h0000_0000);
    $display("supply alarm test done");
    print_verdict();
  end
endmodule

`default_nettype wire
